/* scfi_pkg.sv */
// Shared constants and types of the smartcard fault interrupt logic.
package scfi_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam int NUM_IF = 4;
  localparam logic [7:0] REG_UC_STATUS = 8'h00;
  localparam logic [7:0] REG_UC_SYNC = 8'h09;
  localparam logic [7:0] REG_SAM1_STATUS = 8'h10;
  localparam logic [7:0] REG_SAM2_STATUS = 8'h20;
  localparam logic [7:0] REG_SAM3_STATUS = 8'h30;
  localparam logic [7:0] REG_INT_STATUS = 8'h41;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ST_VCC_FAIL = 0;
  localparam int ST_PRESENCE = 2;
  localparam int ST_OVERCURRENT = 4;
  localparam int ST_MUTE = 5;
  localparam int ST_EARLY = 6;
  localparam int ST_SUP_LIVE = 1;
  localparam int ST_OTP_LIVE = 2;
  localparam int IS_GPIO = 0;
  localparam int IS_SYNC = 1;
  localparam int IS_SUP = 2;
  localparam int IS_OTP = 3;
  localparam int IS_SAM3 = 4;
  localparam int IS_SAM2 = 5;
  localparam int IS_SAM1 = 6;
  localparam int IS_UC = 7;
  localparam int SYNC_RST_BIT = 3;

  // ----------------------------------------------------------------------
  // Reset values and serial counts
  // ----------------------------------------------------------------------
  localparam logic POR_PENDING_RST = 1'h1;
  localparam logic CARD_RST_RST = 1'h0;
  localparam logic [3:0] I2C_BITS = 4'h8;
  localparam logic [3:0] I2C_LAST_TX = 4'h7;
  localparam logic [6:0] I2C_ADDR_DEF = 7'h2A;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK = 3'b010,
    I2C_RX = 3'b011,
    I2C_TX = 3'b100,
    I2C_MACK = 3'b101
  } scfi_i2c_state_e;

endpackage

/* scfi_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module scfi_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  if (W < 1) begin : g_chk
    $error("Synchroniser width must be at least one.");
  end

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_o <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_o <= (s2_q & s3_q) | (sync_o & (s2_q | s3_q));
    end
  end

endmodule

/* scfi_card_status.sv */
// Latched fault bits of one card interface status register.
`timescale 1ns/1ps
module scfi_card_status #(
  parameter bit HAS_PRESENCE = 1'h0
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic vcc_fail_i,
  input wire logic overcurrent_i,
  input wire logic early_i,
  input wire logic mute_i,
  input wire logic async_i,
  input wire logic presence_chg_i,
  input wire logic rd_clr_i,
  input wire logic [7:0] clr_mask_i,
  output logic [7:0] latched_o,
  output logic event_o
);

  logic oc_prev_q;
  logic [7:0] set_m;
  logic [7:0] lat_q;

  always_comb begin
    set_m = 8'h00;
    set_m[scfi_pkg::ST_VCC_FAIL] = vcc_fail_i;
    set_m[scfi_pkg::ST_OVERCURRENT] = overcurrent_i & ~oc_prev_q;
    set_m[scfi_pkg::ST_EARLY] = early_i & async_i;
    set_m[scfi_pkg::ST_MUTE] = mute_i & async_i;
    set_m[scfi_pkg::ST_PRESENCE] = presence_chg_i & HAS_PRESENCE;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      oc_prev_q <= 1'h0;
    end else begin
      oc_prev_q <= overcurrent_i;
    end
  end

  // Only a read of this register clears; a new event wins over the clear.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      lat_q <= scfi_pkg::REG_RESET;
    end else if (rd_clr_i) begin
      lat_q <= (lat_q & ~clr_mask_i) | set_m;
    end else begin
      lat_q <= lat_q | set_m;
    end
  end

  assign latched_o = lat_q;
  assign event_o = |set_m;

endmodule

/* scfi_top.sv */
// Event collection, interrupt line, card reset pins and I2C registers.
`timescale 1ns/1ps
module scfi_top #(
  parameter logic [6:0] I2C_ADDR = scfi_pkg::I2C_ADDR_DEF
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_n_o,
  output logic int_n_oe_o,
  input wire logic [3:0] vcc_oc_i,
  input wire logic vdd_low_i,
  input wire logic otp_i,
  input wire logic card_present_i,
  input wire logic [3:0] vcc_fail_i,
  input wire logic [3:0] atr_early_i,
  input wire logic [3:0] atr_mute_i,
  input wire logic [3:0] card_async_i,
  input wire logic uc_sync_mode_i,
  input wire logic sync_done_i,
  input wire logic gpio_change_i,
  input wire logic [3:0] seq_rst_i,
  output logic [3:0] card_rst_o,
  output logic [7:0] sync_settings_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] iface_off(input int idx);
    case (idx)
      0: iface_off = scfi_pkg::REG_UC_STATUS;
      1: iface_off = scfi_pkg::REG_SAM1_STATUS;
      2: iface_off = scfi_pkg::REG_SAM2_STATUS;
      default: iface_off = scfi_pkg::REG_SAM3_STATUS;
    endcase
  endfunction

  function automatic int iface_irq(input int idx);
    case (idx)
      0: iface_irq = scfi_pkg::IS_UC;
      1: iface_irq = scfi_pkg::IS_SAM1;
      2: iface_irq = scfi_pkg::IS_SAM2;
      default: iface_irq = scfi_pkg::IS_SAM3;
    endcase
  endfunction

  if (I2C_ADDR == 7'h00) begin : g_chk
    $error("I2C address zero is the general call address.");
  end

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  logic [8:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [3:0] oc_s;
  logic low_s;
  logic otp_s;
  logic pres_s;

  scfi_sync #(
    .W(9)
  ) u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i({scl_i, sda_i, vcc_oc_i, vdd_low_i, otp_i, card_present_i}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[8];
  assign sda_s = pins_s[7];
  assign oc_s = pins_s[6:3];
  assign low_s = pins_s[2];
  assign otp_s = pins_s[1];
  assign pres_s = pins_s[0];

  // ----------------------------------------------------------------------
  // I2C slave
  // ----------------------------------------------------------------------
  scfi_pkg::scfi_i2c_state_e state_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic first_q;
  logic rw_q;
  logic nack_q;
  logic sda_oe_q;
  logic wr_pls_q;
  logic rd_pls_q;
  logic [7:0] acc_addr_q;
  logic [7:0] acc_data_q;
  logic [7:0] rd_val;
  logic i2c_start;
  logic i2c_stop;
  logic scl_rise;
  logic scl_fall;
  logic load_tx;

  assign i2c_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign i2c_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign load_tx = scl_fall &
    (((state_q == scfi_pkg::I2C_ACK) && rw_q) ||
     ((state_q == scfi_pkg::I2C_MACK) && !nack_q));

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      scl_prev_q <= 1'h0;
      sda_prev_q <= 1'h0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_q <= scfi_pkg::I2C_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      first_q <= 1'h1;
      rw_q <= 1'h0;
      nack_q <= 1'h0;
      sda_oe_q <= 1'h0;
      wr_pls_q <= 1'h0;
      rd_pls_q <= 1'h0;
      acc_addr_q <= 8'h00;
      acc_data_q <= 8'h00;
    end else begin
      wr_pls_q <= 1'h0;
      rd_pls_q <= 1'h0;
      if (i2c_start) begin
        state_q <= scfi_pkg::I2C_ADDR;
        cnt_q <= 4'h0;
        first_q <= 1'h1;
        sda_oe_q <= 1'h0;
      end else if (i2c_stop) begin
        state_q <= scfi_pkg::I2C_IDLE;
        sda_oe_q <= 1'h0;
      end else if (load_tx) begin
        sh_q <= rd_val;
        sda_oe_q <= ~rd_val[7];
        rd_pls_q <= 1'h1;
        acc_addr_q <= ptr_q;
        acc_data_q <= rd_val;
        ptr_q <= ptr_q + 8'h01;
        cnt_q <= 4'h0;
        state_q <= scfi_pkg::I2C_TX;
      end else begin
        unique case (state_q)
          scfi_pkg::I2C_IDLE: begin
            sda_oe_q <= 1'h0;
          end
          scfi_pkg::I2C_ADDR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == scfi_pkg::I2C_BITS) begin
              if (sh_q[7:1] == I2C_ADDR) begin
                sda_oe_q <= 1'h1;
                rw_q <= sh_q[0];
                state_q <= scfi_pkg::I2C_ACK;
              end else begin
                state_q <= scfi_pkg::I2C_IDLE;
              end
            end
          end
          scfi_pkg::I2C_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'h0;
              cnt_q <= 4'h0;
              state_q <= scfi_pkg::I2C_RX;
            end
          end
          scfi_pkg::I2C_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == scfi_pkg::I2C_BITS) begin
              sda_oe_q <= 1'h1;
              state_q <= scfi_pkg::I2C_ACK;
              if (first_q) begin
                ptr_q <= sh_q;
                first_q <= 1'h0;
              end else begin
                wr_pls_q <= 1'h1;
                acc_addr_q <= ptr_q;
                acc_data_q <= sh_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          scfi_pkg::I2C_TX: begin
            if (scl_fall) begin
              if (cnt_q == scfi_pkg::I2C_LAST_TX) begin
                sda_oe_q <= 1'h0;
                state_q <= scfi_pkg::I2C_MACK;
              end else begin
                sda_oe_q <= ~sh_q[6];
                sh_q <= {sh_q[6:0], 1'h0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          scfi_pkg::I2C_MACK: begin
            if (scl_rise) begin
              nack_q <= sda_s;
            end else if (scl_fall) begin
              state_q <= scfi_pkg::I2C_IDLE;
            end
          end
          default: begin
            state_q <= scfi_pkg::I2C_IDLE;
            sda_oe_q <= 1'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------------
  // Only the VCC comparators feed the overcurrent path; clock and reset
  // pin current limits have no input here and never deactivate a card.
  logic low_prev_q;
  logic otp_prev_q;
  logic pres_prev_q;
  logic low_rise;
  logic otp_rise;
  logic pres_chg;
  logic sync_evt;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      low_prev_q <= 1'h0;
      otp_prev_q <= 1'h0;
      pres_prev_q <= 1'h0;
    end else begin
      low_prev_q <= low_s;
      otp_prev_q <= otp_s;
      pres_prev_q <= pres_s;
    end
  end

  assign low_rise = low_s & ~low_prev_q;
  assign otp_rise = otp_s & ~otp_prev_q;
  assign pres_chg = pres_s ^ pres_prev_q;
  assign sync_evt = sync_done_i & uc_sync_mode_i;

  // ----------------------------------------------------------------------
  // Card interface status registers
  // ----------------------------------------------------------------------
  logic [7:0] lat_w [scfi_pkg::NUM_IF];
  logic [scfi_pkg::NUM_IF-1:0] if_evt;

  for (genvar i = 0; i < scfi_pkg::NUM_IF; i++) begin : g_if
    scfi_card_status #(
      .HAS_PRESENCE((i == 0) ? 1'h1 : 1'h0)
    ) u_status (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .vcc_fail_i(vcc_fail_i[i]),
      .overcurrent_i(oc_s[i]),
      .early_i(atr_early_i[i]),
      .mute_i(atr_mute_i[i]),
      .async_i(card_async_i[i]),
      .presence_chg_i((i == 0) ? pres_chg : 1'h0),
      .rd_clr_i(rd_pls_q && acc_addr_q == iface_off(i)),
      .clr_mask_i(acc_data_q),
      .latched_o(lat_w[i]),
      .event_o(if_evt[i])
    );
  end

  // ----------------------------------------------------------------------
  // Interrupt status and line
  // ----------------------------------------------------------------------
  logic [7:0] irq_q;
  logic [7:0] irq_set;
  logic por_q;
  logic irq_rd;
  logic int_oe_q;
  logic pin_low_q;

  assign irq_rd = rd_pls_q && acc_addr_q == scfi_pkg::REG_INT_STATUS;

  always_comb begin
    irq_set = 8'h00;
    irq_set[scfi_pkg::IS_GPIO] = gpio_change_i;
    irq_set[scfi_pkg::IS_SYNC] = sync_evt;
    irq_set[scfi_pkg::IS_SUP] = low_rise;
    irq_set[scfi_pkg::IS_OTP] = otp_rise;
    for (int i = 0; i < scfi_pkg::NUM_IF; i++) begin
      irq_set[iface_irq(i)] = if_evt[i];
    end
  end

  // A read clears only the bits it returned; a new event wins.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      irq_q <= scfi_pkg::REG_RESET;
    end else if (irq_rd) begin
      irq_q <= (irq_q & ~acc_data_q) | irq_set;
    end else begin
      irq_q <= irq_q | irq_set;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      por_q <= scfi_pkg::POR_PENDING_RST;
    end else if (irq_rd) begin
      por_q <= 1'h0;
    end
  end

  // The line is only ever pulled low or released.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      int_oe_q <= 1'h0;
      pin_low_q <= 1'h0;
    end else begin
      int_oe_q <= (|irq_q) | por_q;
      pin_low_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Sync settings register and card reset pins
  // ----------------------------------------------------------------------
  logic [7:0] sync_q;
  logic host_own_q;
  logic [3:0] rst_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sync_q <= scfi_pkg::REG_RESET;
    end else if (wr_pls_q && acc_addr_q == scfi_pkg::REG_UC_SYNC) begin
      sync_q <= acc_data_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      host_own_q <= 1'h0;
    end else if (!uc_sync_mode_i) begin
      host_own_q <= 1'h0;
    end else if (sync_done_i) begin
      host_own_q <= 1'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rst_q <= {4{scfi_pkg::CARD_RST_RST}};
    end else begin
      rst_q[3:1] <= seq_rst_i[3:1];
      rst_q[0] <= host_own_q ? sync_q[scfi_pkg::SYNC_RST_BIT]
                             : seq_rst_i[0];
    end
  end

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  always_comb begin
    case (ptr_q)
      scfi_pkg::REG_UC_STATUS: rd_val = lat_w[0];
      scfi_pkg::REG_UC_SYNC: rd_val = sync_q;
      scfi_pkg::REG_SAM1_STATUS: begin
        rd_val = lat_w[1];
        rd_val[scfi_pkg::ST_SUP_LIVE] = low_s;
        rd_val[scfi_pkg::ST_OTP_LIVE] = otp_s;
      end
      scfi_pkg::REG_SAM2_STATUS: rd_val = lat_w[2];
      scfi_pkg::REG_SAM3_STATUS: rd_val = lat_w[3];
      scfi_pkg::REG_INT_STATUS: rd_val = irq_q;
      default: rd_val = scfi_pkg::RD_UNMAPPED;
    endcase
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sda_o = pin_low_q;
  assign sda_oe_o = sda_oe_q;
  assign int_n_o = pin_low_q;
  assign int_n_oe_o = int_oe_q;
  assign card_rst_o = rst_q;
  assign sync_settings_o = sync_q;

endmodule

/* scfi_chk.sv */
// Assertion checker for the interrupt line and card reset ports.
`timescale 1ns/1ps
module scfi_chk (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic int_n_o,
  input wire logic int_n_oe_o,
  input wire logic [3:0] vcc_oc_i,
  input wire logic vdd_low_i,
  input wire logic otp_i,
  input wire logic [3:0] vcc_fail_i,
  input wire logic [3:0] atr_early_i,
  input wire logic [3:0] atr_mute_i,
  input wire logic [3:0] card_async_i,
  input wire logic uc_sync_mode_i,
  input wire logic sync_done_i,
  input wire logic gpio_change_i,
  input wire logic [3:0] seq_rst_i,
  input wire logic [3:0] card_rst_o
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_od; int_n_o == 1'h0 && sda_o == 1'h0; endproperty
  a_od: assert property (p_od) else $error("pin value not low");
  property p_fail; |vcc_fail_i |-> ##2 int_n_oe_o; endproperty
  a_fail: assert property (p_fail) else $error("ramp irq");
  property p_atr;
    |((atr_early_i | atr_mute_i) & card_async_i) |-> ##2 int_n_oe_o;
  endproperty
  a_atr: assert property (p_atr) else $error("atr irq");
  property p_sync;
    sync_done_i && uc_sync_mode_i |-> ##2 int_n_oe_o;
  endproperty
  a_sync: assert property (p_sync) else $error("sync irq");
  property p_gpio; gpio_change_i |-> ##2 int_n_oe_o; endproperty
  a_gpio: assert property (p_gpio) else $error("gpio irq");
  property p_oc;
    (vcc_oc_i & ~$past(vcc_oc_i)) != 4'h0 |-> ##[2:12] int_n_oe_o;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent irq");
  property p_live;
    $rose(vdd_low_i) || $rose(otp_i) |-> ##[2:12] int_n_oe_o;
  endproperty
  a_live: assert property (p_live) else $error("live irq");
  property p_hold; int_n_oe_o && scl_i && $past(scl_i) |=> int_n_oe_o;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_rst_sam;
    $past(reset_n_i) |-> card_rst_o[3:1] == $past(seq_rst_i[3:1]);
  endproperty
  a_rst_sam: assert property (p_rst_sam) else $error("sam reset");
  property p_rst_uc;
    card_async_i[0] && !uc_sync_mode_i && !$past(uc_sync_mode_i) &&
    !$past(uc_sync_mode_i, 2) && $past(reset_n_i) |->
    card_rst_o[0] == $past(seq_rst_i[0]);
  endproperty
  a_rst_uc: assert property (p_rst_uc) else $error("user reset");
  c_fail: cover property (|vcc_fail_i ##2 int_n_oe_o);
  c_sync: cover property (sync_done_i && uc_sync_mode_i);
  c_rel: cover property ($fell(int_n_oe_o));
endmodule
bind scfi_top scfi_chk i_scfi_chk (.clock_i, .reset_n_i, .scl_i, .sda_o,
  .int_n_o, .int_n_oe_o, .vcc_oc_i, .vdd_low_i, .otp_i, .vcc_fail_i,
  .atr_early_i, .atr_mute_i, .card_async_i, .uc_sync_mode_i, .sync_done_i,
  .gpio_change_i, .seq_rst_i, .card_rst_o);

/* scfi_host_mdl.sv */
// Behavioural I2C host that reaches the register map.
`timescale 1ns/1ps
module scfi_host_mdl #(
  parameter logic [6:0] ADDR = scfi_pkg::I2C_ADDR_DEF
) (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // ------------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------------
  initial begin
    scl_o = 1'h1;
    sda_oe_o = 1'h0;
  end
  task automatic stp(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic start();
    stp(2);
    sda_oe_o <= 1'h0;
    stp(10);
    scl_o <= 1'h1;
    stp(10);
    sda_oe_o <= 1'h1;
    stp(10);
    scl_o <= 1'h0;
  endtask
  task automatic stop();
    stp(2);
    sda_oe_o <= 1'h1;
    stp(10);
    scl_o <= 1'h1;
    stp(10);
    sda_oe_o <= 1'h0;
    stp(10);
  endtask
  task automatic bitx(input logic b, output logic r);
    stp(2);
    sda_oe_o <= !b;
    stp(10);
    scl_o <= 1'h1;
    stp(10);
    r = sda_i;
    scl_o <= 1'h0;
  endtask
  task automatic send8(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'h1, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send8({ADDR, 1'h0});
    send8(a);
    send8(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic n;
    start();
    send8({ADDR, 1'h0});
    send8(a);
    start();
    send8({ADDR, 1'h1});
    for (int i = 7; i >= 0; i--) begin
      bitx(1'h1, d[i]);
    end
    bitx(1'h1, n);
    stop();
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the smartcard fault interrupt logic.
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic scl_i, host_oe, sda_w, sda_o, sda_oe_o, int_n_o, int_n_oe_o;
  logic [3:0] vcc_oc_i = 4'h0, vcc_fail_i = 4'h0, atr_early_i = 4'h0;
  logic [3:0] atr_mute_i = 4'h0, card_async_i = 4'hF, seq_rst_i = 4'h0;
  logic vdd_low_i = 1'h0, otp_i = 1'h0, card_present_i = 1'h0;
  logic uc_sync_mode_i = 1'h0, sync_done_i = 1'h0, gpio_change_i = 1'h0;
  logic [3:0] card_rst_o;
  logic [7:0] sync_settings_o, rv;
  logic [7:0] sa [4] = '{scfi_pkg::REG_UC_STATUS, scfi_pkg::REG_SAM1_STATUS,
    scfi_pkg::REG_SAM2_STATUS, scfi_pkg::REG_SAM3_STATUS};
  int err_total = 0;
  int n_compared = 0;
  assign sda_w = !(sda_oe_o | host_oe);
  always #20 clock_i = !clock_i;
  scfi_top i_scfi_top (.clock_i, .reset_n_i, .scl_i, .sda_i(sda_w), .sda_o,
    .sda_oe_o, .int_n_o, .int_n_oe_o, .vcc_oc_i, .vdd_low_i, .otp_i,
    .card_present_i, .vcc_fail_i, .atr_early_i, .atr_mute_i, .card_async_i,
    .uc_sync_mode_i, .sync_done_i, .gpio_change_i, .seq_rst_i, .card_rst_o,
    .sync_settings_o);
  scfi_host_mdl i_scfi_host_mdl (.clock_i, .sda_i(sda_w), .scl_o(scl_i),
    .sda_oe_o(host_oe));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] e);
    i_scfi_host_mdl.rd(a, rv);
    chk(nm, rv, e);
  endtask
  task automatic ev(input int k, input int i);
    logic [3:0] m;
    m = 4'h1 << i;
    @(posedge clock_i);
    case (k)
      0: vcc_fail_i <= m;
      1: atr_early_i <= m;
      2: atr_mute_i <= m;
      3: gpio_change_i <= 1'h1;
      default: sync_done_i <= 1'h1;
    endcase
    @(posedge clock_i);
    vcc_fail_i <= 4'h0;
    atr_early_i <= 4'h0;
    atr_mute_i <= 4'h0;
    gpio_change_i <= 1'h0;
    sync_done_i <= 1'h0;
  endtask
  task automatic evt(input int k, input int i, input logic [7:0] a,
                     input logic [7:0] se, input logic [7:0] ie);
    ev(k, i);
    cyc(3);
    chk("int line", {7'h0, int_n_oe_o}, {7'h0, ie != 8'h0});
    rdc("isr", scfi_pkg::REG_INT_STATUS, ie);
    chk("int after read", {7'h0, int_n_oe_o}, 8'h00);
    rdc("isr again", scfi_pkg::REG_INT_STATUS, 8'h00);
    rdc("status", a, se);
    rdc("status again", a, 8'h00);
  endtask
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    cyc(90000);
    err_total++;
    test_done();
  end
  initial begin
    cyc(3);
    reset_n_i <= 1'h1;
    cyc(20);
    chk("por int", {7'h0, int_n_oe_o}, 8'h01);
    chk("sync out reset", sync_settings_o, 8'h00);
    rdc("isr por", 8'h41, 8'h00);
    chk("por released", {7'h0, int_n_oe_o}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      evt(0, i, sa[i], 8'h01, 8'h80 >> i);
    end
    evt(1, 1, sa[1], 8'h40, 8'h40);
    evt(1, 2, sa[2], 8'h40, 8'h20);
    evt(2, 0, sa[0], 8'h20, 8'h80);
    evt(2, 3, sa[3], 8'h20, 8'h10);
    evt(3, 0, 8'h05, 8'h00, 8'h01);
    evt(4, 0, 8'h05, 8'h00, 8'h00);
    card_async_i <= 4'h6;
    evt(1, 3, sa[3], 8'h00, 8'h00);
    evt(2, 0, sa[0], 8'h00, 8'h00);
    uc_sync_mode_i <= 1'h1;
    seq_rst_i <= 4'h1;
    cyc(3);
    chk("rst before done", {4'h0, card_rst_o}, 8'h01);
    evt(4, 0, 8'h05, 8'h00, 8'h02);
    i_scfi_host_mdl.wr(8'h09, 8'h08);
    chk("sync out", sync_settings_o, 8'h08);
    seq_rst_i <= 4'h0;
    cyc(3);
    chk("rst host high", {4'h0, card_rst_o}, 8'h01);
    i_scfi_host_mdl.wr(8'h09, 8'h00);
    seq_rst_i <= 4'h1;
    cyc(3);
    chk("rst host low", {4'h0, card_rst_o}, 8'h00);
    rdc("sync read", 8'h09, 8'h00);
    uc_sync_mode_i <= 1'h0;
    card_async_i <= 4'hF;
    seq_rst_i <= 4'h5;
    cyc(4);
    chk("rst sequencer", {4'h0, card_rst_o}, 8'h05);
    vcc_oc_i <= 4'h4;
    cyc(12);
    chk("oc int", {7'h0, int_n_oe_o}, 8'h01);
    rdc("oc isr", 8'h41, 8'h20);
    rdc("oc status", 8'h20, 8'h10);
    rdc("oc status again", 8'h20, 8'h00);
    vcc_oc_i <= 4'h0;
    card_present_i <= 1'h1;
    cyc(12);
    rdc("pres isr", 8'h41, 8'h80);
    rdc("pres isr again", 8'h41, 8'h00);
    rdc("pres status", 8'h00, 8'h04);
    rdc("pres status again", 8'h00, 8'h00);
    for (int k = 0; k < 2; k++) begin
      vdd_low_i <= (k == 0);
      otp_i <= (k == 1);
      cyc(12);
      rdc("live isr", 8'h41, 8'h04 << k);
      rdc("live bit", 8'h10, 8'h02 << k);
      rdc("live bit held", 8'h10, 8'h02 << k);
      vdd_low_i <= 1'h0;
      otp_i <= 1'h0;
      cyc(12);
      rdc("live bit gone", 8'h10, 8'h00);
    end
    test_done();
  end
endmodule
